// ===== hw/monitor_params.svh
/*
  Offsets, field positions, reset values and timing figures of the monitor
  control block.
  Assumes inclusion by bare name from the package and the main module.
*/
`ifndef MONITOR_PARAMS_SVH
`define MONITOR_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define OFS_FACTORY_TEST 8'h15
`define OFS_FAN_DRIVE 8'h19
`define OFS_MAKER_CODE 8'h3e
`define OFS_SILICON_REV 8'h3f
`define OFS_CONTROL_CONFIG 8'h40
`define OFS_ALERT_STATUS_1 8'h41
`define OFS_ALERT_STATUS_2 8'h42
`define OFS_ALERT_MASK_1 8'h43
`define OFS_ALERT_MASK_2 8'h44
`define OFS_INTRUSION_CLEAR 8'h46
`define OFS_VCODE_LOW 8'h47
`define OFS_BUS_ADDR 8'h48
`define OFS_VCODE_HIGH 8'h49
`define OFS_THERMAL_CONFIG 8'h4b

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_CONFIG 8'h08
`define RST_ZERO8 8'h00
`define RST_FAN_DRIVE 8'hff
`define RST_THERMAL 8'h01
`define RST_ADDR_HI 6'h0b
`define VCODE_LOW_HI 4'h5
`define VCODE_HIGH_HI 7'h40

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define CFG_START 0
`define CFG_ALERT_EN 1
`define CFG_ALERT_CLR 3
`define CFG_SW_RESET 4
`define CFG_CHS_RESET 6
`define CFG_INIT 7
`define CFG_WMASK 8'hdb
`define MASK2_RST_MODE 7
`define CHS_CLR_BIT 7
`define THERM_LSB_BIT 7
`define STAT2_CHS_BIT 4

////////////////////////////////////////////////////////////////////////////////
// Timing
`define CLK_PERIOD_NS 40
`define RST_PULSE_NS 20000000
`define CLK_TOL_PCT 10
`define LOOP_NS 1000000000
`define LOOP_CHANNELS 9
`define CHAN_LAST 4'h8
`define PIN_GUARD 4'h8
`define CHS_PULSE_LAST 5'h1f

////////////////////////////////////////////////////////////////////////////////
// Counter widths
`define RST_CNT_W 20
`define SLOT_CNT_W 22

`endif

// ===== hw/monitor_pkg.sv
/*
  Types of the monitor control block: state enums and the state record.
  Assumes monitor_params.svh on the include path.
*/
`include "monitor_params.svh"

package monitor_pkg;

  typedef enum logic {
    RST_IDLE = 1'b0,
    RST_HOLD = 1'b1
  } reset_state_e;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_RUN = 1'b1
  } seq_state_e;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [5:0] addr_hi;
    logic [7:0] therm;
    logic [7:0] test;
    logic [7:0] fan;
    logic [7:0] rdata;
    reset_state_e rst_st;
    logic [`RST_CNT_W-1:0] rst_cnt;
    logic [3:0] rst_gd;
    logic rst_oe;
    logic chs_clr;
    logic [4:0] chs_cnt;
    logic [3:0] chs_gd;
    logic chs_oe;
    logic alert_n;
    seq_state_e seq_st;
    logic [`SLOT_CNT_W-1:0] slot_cnt;
    logic [3:0] chan;
    logic conv_start;
    logic [6:0] slave_addr;
  } state_s;

endpackage

// ===== hw/monitor_reset_config_control.sv
/*
  Reset, configuration and register-map control of a hardware monitor:
  reset pin pulses, chassis pin clearing, alert output, round-robin sequencer.
  Assumes a serial front end on clk issuing one-cycle register strobes, and a
  conversion datapath that takes conv_start/conv_chan and reports limit events.
*/
`timescale 1ns/10ps
`include "monitor_params.svh"

module monitor_reset_config_control #(
  parameter int unsigned RST_PULSE_CYCLES =
    ((`RST_PULSE_NS / `CLK_PERIOD_NS) * (100 + `CLK_TOL_PCT)) / 100,
  parameter int unsigned SLOT_CYCLES = `LOOP_NS / `CLK_PERIOD_NS / `LOOP_CHANNELS,
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  parameter logic [7:0] SILICON_REV = 8'h03
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [6:0] slave_addr,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  input wire logic chassis_intrusion_pin_in,
  output logic chassis_intrusion_pin_out,
  output logic chassis_intrusion_pin_oe,
  output logic alert_n,
  input wire logic [3:0] cpu_voltage_code_pins,
  input wire logic cpu_voltage_code_msb_pin,
  input wire logic addr_strap_lsb,
  input wire logic addr_strap_msb,
  input wire logic [7:0] status1_set,
  input wire logic [7:0] status2_set,
  input wire logic temp_lsb,
  output logic conv_start,
  output logic [3:0] conv_chan,
  output logic monitor_busy,
  output logic [7:0] fan_drive_level
);

  localparam logic [`RST_CNT_W-1:0] RST_LAST = `RST_CNT_W'(RST_PULSE_CYCLES - 1);
  localparam logic [`SLOT_CNT_W-1:0] SLOT_LAST = `SLOT_CNT_W'(SLOT_CYCLES - 1);

  localparam monitor_pkg::state_s STATE_RST = '{
    cfg: `RST_CONFIG,
    stat1: `RST_ZERO8,
    stat2: `RST_ZERO8,
    mask1: `RST_ZERO8,
    mask2: `RST_ZERO8,
    addr_hi: `RST_ADDR_HI,
    therm: `RST_THERMAL,
    test: `RST_ZERO8,
    fan: `RST_FAN_DRIVE,
    rdata: `RST_ZERO8,
    rst_st: monitor_pkg::RST_HOLD,
    rst_cnt: '0,
    rst_gd: '0,
    rst_oe: 1'b1,
    chs_clr: 1'b0,
    chs_cnt: '0,
    chs_gd: '0,
    chs_oe: 1'b0,
    alert_n: 1'b1,
    seq_st: monitor_pkg::SEQ_IDLE,
    slot_cnt: '0,
    chan: '0,
    conv_start: 1'b0,
    slave_addr: '0
  };

  monitor_pkg::state_s state_r;
  monitor_pkg::state_s state_nxt;

  logic rst_lvl;
  logic chs_lvl;
  logic [4:0] vcode_lvl;
  logic [1:0] strap_lvl;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, running in standby too
  pin_sync #(.WIDTH(1), .INIT(1'b1)) u_rst_sync (
    .clk(clk),
    .rst(rst),
    .pin(rst_pin_in),
    .level(rst_lvl)
  );

  pin_sync #(.WIDTH(1), .INIT(1'b0)) u_chs_sync (
    .clk(clk),
    .rst(rst),
    .pin(chassis_intrusion_pin_in),
    .level(chs_lvl)
  );

  pin_sync #(.WIDTH(5), .INIT(5'h00)) u_vcode_sync (
    .clk(clk),
    .rst(rst),
    .pin({cpu_voltage_code_msb_pin, cpu_voltage_code_pins}),
    .level(vcode_lvl)
  );

  pin_sync #(.WIDTH(2), .INIT(2'h0)) u_strap_sync (
    .clk(clk),
    .rst(rst),
    .pin({addr_strap_msb, addr_strap_lsb}),
    .level(strap_lvl)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic init_req;
    logic run_en;
    logic chs_evt;
    logic [7:0] rd;
    init_req = 1'b0;
    run_en = state_r.cfg[`CFG_START] & ~state_r.cfg[`CFG_ALERT_CLR];
    chs_evt = ~state_r.chs_oe & (state_r.chs_gd == 4'h0) & chs_lvl;
    rd = `RST_ZERO8;
    state_nxt = state_r;
    state_nxt.conv_start = 1'b0;
    state_nxt.slave_addr = {state_r.addr_hi[4:0], strap_lvl};

    // Read mux
    unique case (reg_addr)
      `OFS_FACTORY_TEST: rd = state_r.test;
      `OFS_FAN_DRIVE: rd = state_r.fan;
      `OFS_MAKER_CODE: rd = MAKER_CODE;
      `OFS_SILICON_REV: rd = SILICON_REV;
      `OFS_CONTROL_CONFIG: rd = state_r.cfg;
      `OFS_ALERT_STATUS_1: rd = state_r.stat1;
      `OFS_ALERT_STATUS_2: rd = state_r.stat2;
      `OFS_ALERT_MASK_1: rd = state_r.mask1;
      `OFS_ALERT_MASK_2: rd = state_r.mask2;
      `OFS_INTRUSION_CLEAR: rd = {state_r.chs_clr, 7'h00};
      `OFS_VCODE_LOW: rd = {`VCODE_LOW_HI, vcode_lvl[3:0]};
      `OFS_BUS_ADDR: rd = {state_r.addr_hi, strap_lvl};
      `OFS_VCODE_HIGH: rd = {`VCODE_HIGH_HI, vcode_lvl[4]};
      `OFS_THERMAL_CONFIG: rd = {temp_lsb, state_r.therm[6:0]};
      default: rd = `RST_ZERO8;
    endcase

    // Status: clear on read, a set in the same cycle wins
    if (reg_rd) begin
      state_nxt.rdata = rd;
      if (reg_addr == `OFS_ALERT_STATUS_1) begin
        state_nxt.stat1 = `RST_ZERO8;
      end
      if (reg_addr == `OFS_ALERT_STATUS_2) begin
        state_nxt.stat2 = `RST_ZERO8;
      end
    end
    state_nxt.stat1 = state_nxt.stat1 | status1_set;
    state_nxt.stat2 = state_nxt.stat2 | status2_set;
    state_nxt.stat2[`STAT2_CHS_BIT] = state_nxt.stat2[`STAT2_CHS_BIT] | chs_evt;

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `OFS_FACTORY_TEST: state_nxt.test = reg_wdata;
        `OFS_FAN_DRIVE: state_nxt.fan = reg_wdata;
        `OFS_CONTROL_CONFIG: begin
          state_nxt.cfg = reg_wdata & `CFG_WMASK;
          init_req = reg_wdata[`CFG_INIT];
        end
        `OFS_ALERT_MASK_1: state_nxt.mask1 = reg_wdata;
        `OFS_ALERT_MASK_2: state_nxt.mask2 = reg_wdata;
        `OFS_INTRUSION_CLEAR: begin
          if (reg_wdata[`CHS_CLR_BIT]) begin
            state_nxt.chs_clr = 1'b1;
            state_nxt.chs_cnt = '0;
          end
        end
        `OFS_BUS_ADDR: state_nxt.addr_hi = reg_wdata[7:2];
        `OFS_THERMAL_CONFIG: state_nxt.therm = reg_wdata;
        default: state_nxt.test = state_nxt.test;
      endcase
    end

    // Reset pin sequencer
    unique case (state_r.rst_st)
      monitor_pkg::RST_IDLE: begin
        if (state_r.rst_gd == 4'h0 && !rst_lvl) begin
          init_req = 1'b1;
          state_nxt.rst_st = monitor_pkg::RST_HOLD;
          state_nxt.rst_cnt = '0;
          state_nxt.rst_oe = 1'b1;
        end else if (state_r.cfg[`CFG_SW_RESET] && state_r.mask2[`MASK2_RST_MODE]) begin
          state_nxt.rst_st = monitor_pkg::RST_HOLD;
          state_nxt.rst_cnt = '0;
          state_nxt.rst_oe = 1'b1;
          state_nxt.cfg[`CFG_SW_RESET] = 1'b0;
        end
        if (state_r.rst_gd != 4'h0) begin
          state_nxt.rst_gd = state_r.rst_gd - 4'h1;
        end
      end
      monitor_pkg::RST_HOLD: begin
        if (state_r.rst_cnt == RST_LAST) begin
          state_nxt.rst_st = monitor_pkg::RST_IDLE;
          state_nxt.rst_oe = 1'b0;
          state_nxt.rst_gd = `PIN_GUARD;
        end else begin
          state_nxt.rst_cnt = state_r.rst_cnt + `RST_CNT_W'(1);
        end
      end
    endcase

    // Defaults on initialisation, fan level kept
    if (init_req) begin
      state_nxt.cfg = `RST_CONFIG;
      state_nxt.stat1 = `RST_ZERO8;
      state_nxt.stat2 = `RST_ZERO8;
      state_nxt.mask1 = `RST_ZERO8;
      state_nxt.mask2 = `RST_ZERO8;
      state_nxt.addr_hi = `RST_ADDR_HI;
      state_nxt.therm = `RST_THERMAL;
      state_nxt.test = `RST_ZERO8;
      state_nxt.chs_clr = 1'b0;
    end

    // Chassis pin clearing
    state_nxt.chs_oe = state_r.cfg[`CFG_CHS_RESET] | state_r.chs_clr;
    if (state_r.chs_clr && !init_req &&
      !(reg_wr && reg_addr == `OFS_INTRUSION_CLEAR && reg_wdata[`CHS_CLR_BIT])) begin
      if (state_r.chs_cnt == `CHS_PULSE_LAST) begin
        state_nxt.chs_clr = 1'b0;
      end else begin
        state_nxt.chs_cnt = state_r.chs_cnt + 5'h01;
      end
    end
    if (state_r.chs_oe) begin
      state_nxt.chs_gd = `PIN_GUARD;
    end else if (state_r.chs_gd != 4'h0) begin
      state_nxt.chs_gd = state_r.chs_gd - 4'h1;
    end

    // Alert output
    state_nxt.alert_n = ~(state_r.cfg[`CFG_ALERT_EN] & ~state_r.cfg[`CFG_ALERT_CLR] &
      ((|(state_r.stat1 & ~state_r.mask1)) | (|(state_r.stat2 & ~state_r.mask2))));

    // Round-robin sequencer
    unique case (state_r.seq_st)
      monitor_pkg::SEQ_IDLE: begin
        if (run_en) begin
          state_nxt.seq_st = monitor_pkg::SEQ_RUN;
          state_nxt.chan = 4'h0;
          state_nxt.slot_cnt = '0;
        end
      end
      monitor_pkg::SEQ_RUN: begin
        state_nxt.conv_start = (state_r.slot_cnt == '0);
        if (state_r.slot_cnt == SLOT_LAST) begin
          state_nxt.slot_cnt = '0;
          if (state_r.chan == `CHAN_LAST) begin
            state_nxt.chan = 4'h0;
            if (!run_en) begin
              state_nxt.seq_st = monitor_pkg::SEQ_IDLE;
            end
          end else begin
            state_nxt.chan = state_r.chan + 4'h1;
          end
        end else begin
          state_nxt.slot_cnt = state_r.slot_cnt + `SLOT_CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = state_r.rdata;
  assign slave_addr = state_r.slave_addr;
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = state_r.rst_oe;
  assign chassis_intrusion_pin_out = 1'b0;
  assign chassis_intrusion_pin_oe = state_r.chs_oe;
  assign alert_n = state_r.alert_n;
  assign conv_start = state_r.conv_start;
  assign conv_chan = state_r.chan;
  assign monitor_busy = (state_r.seq_st == monitor_pkg::SEQ_RUN);
  assign fan_drive_level = state_r.fan;

endmodule

// ===== hw/pin_sync.sv
/*
  Three-stage synchroniser for pin inputs; the level follows once the
  second and third stages agree.
  Assumes pins asynchronous to clk.
*/
`timescale 1ns/10ps

module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sync_s;

  sync_s state_r;
  sync_s state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.s1 = pin;
    state_nxt.s2 = state_r.s1;
    state_nxt.s3 = state_r.s2;
    state_nxt.lvl = (~(state_r.s2 ^ state_r.s3) & state_r.s3) | ((state_r.s2 ^ state_r.s3) & state_r.lvl);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign level = state_r.lvl;

endmodule

// ===== tb/host_pins_model.sv
/*
  Board side of the reset and chassis pins: pulled-up reset wire, intrusion latch.
  Assumes device pin enables high while pulling low.
*/
`timescale 1ns/10ps

module host_pins_model (
  input wire logic clk,
  input wire logic pull_req,
  input wire logic intrude,
  input wire logic rst_oe,
  input wire logic chs_oe,
  output logic rst_level,
  output logic chs_level
);
  logic latch_r = 1'b0;

  // Wired low by either party, else pull-up
  assign rst_level = !(rst_oe || pull_req);
  // Latch cleared while the device pulls low
  always @(posedge clk) begin
    if (chs_oe) latch_r <= 1'b0;
    else if (intrude) latch_r <= 1'b1;
  end
  assign chs_level = latch_r && !chs_oe;
endmodule

// ===== tb/monitor_checker.sv
/*
  Port checks of the monitor control block.
  Assumes binding onto monitor_reset_config_control.
*/
`timescale 1ns/10ps

module monitor_checker #(
  parameter int unsigned RST_PULSE_CYCLES = 20,
  parameter int unsigned SLOT_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [6:0] slave_addr,
  input wire logic rst_pin_in,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic chassis_intrusion_pin_out,
  input wire logic chassis_intrusion_pin_oe,
  input wire logic addr_strap_lsb,
  input wire logic addr_strap_msb,
  input wire logic conv_start,
  input wire logic [3:0] conv_chan,
  input wire logic monitor_busy
);
  int unsigned oe_cnt_r;
  int unsigned gap_r;
  logic [3:0] last_r;
  logic [3:0] live_r;

  // Pulse length, slot gap and time since reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_cnt_r <= 0;
      gap_r <= 0;
      last_r <= 4'h0;
      live_r <= 4'h0;
    end else begin
      oe_cnt_r <= rst_pin_oe ? oe_cnt_r + 1 : 0;
      gap_r <= conv_start ? 0 : gap_r + 1;
      last_r <= conv_start ? conv_chan : last_r;
      live_r <= (live_r == 4'hf) ? live_r : live_r + 4'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_pulse_width: assert property ($fell(rst_pin_oe) |-> oe_cnt_r >= RST_PULSE_CYCLES)
    else $error("reset pin pulse too short");
  chk_open_drain: assert property (!rst_pin_out && !chassis_intrusion_pin_out)
    else $error("pin driven high");
  chk_conv_gated: assert property (conv_start |-> monitor_busy && conv_chan <= 4'h8)
    else $error("conversion outside loop");
  chk_loop_first: assert property ($rose(monitor_busy) |-> ##1 conv_start && conv_chan == 4'h0)
    else $error("loop not started at temperature");
  chk_slot_order: assert property (conv_start && conv_chan != 4'h0 |->
    gap_r == SLOT_CYCLES - 1 && conv_chan == last_r + 4'h1)
    else $error("channel order or spacing wrong");
  chk_chs_clear: assert property (reg_wr && reg_addr == 8'h46 && reg_wdata[7] |-> ##2 chassis_intrusion_pin_oe)
    else $error("chassis pin not driven");
  chk_pin_pull: assert property ((!rst_pin_oe && !rst_pin_in)[*6] |-> ##[0:10] rst_pin_oe)
    else $error("outside reset not held");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  chk_strap_mirror: assert property ((live_r == 4'hf && $stable({addr_strap_msb, addr_strap_lsb}))[*6] |->
    slave_addr[1:0] == {addr_strap_msb, addr_strap_lsb})
    else $error("address straps not mirrored");
endmodule

bind monitor_reset_config_control monitor_checker #(
  .RST_PULSE_CYCLES(RST_PULSE_CYCLES),
  .SLOT_CYCLES(SLOT_CYCLES)
) u_monitor_checker (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .slave_addr,
  .rst_pin_in, .rst_pin_out, .rst_pin_oe, .chassis_intrusion_pin_out, .chassis_intrusion_pin_oe,
  .addr_strap_lsb, .addr_strap_msb, .conv_start, .conv_chan, .monitor_busy);

// ===== tb/monitor_reset_config_control_tb.sv
/*
  Self-checking bench of the monitor control block.
  Assumes host_pins_model and the bound checker.
*/
`timescale 1ns/10ps

module monitor_reset_config_control_tb;
  localparam logic [7:0] MAKER = 8'h3c; // Arbitrary
  localparam logic [7:0] REV = 8'h07; // Arbitrary
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, fan, set1 = 8'h00, set2 = 8'h00;
  logic [6:0] slave_addr;
  logic rst_in, rst_out, rst_oe, chs_in, chs_out, chs_oe, alert_n, conv_start, busy;
  logic [3:0] conv_chan, vcode = 4'h0;
  logic vmsb = 1'b0, a0 = 1'b0, a1 = 1'b0, tlsb = 1'b0, pull_req = 1'b0, intrude = 1'b0;
  logic [31:0] lfsr = 32'haf94;
  logic [7:0] exp_q[$];
  int fail_count = 0, checks_done = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  monitor_reset_config_control #(.RST_PULSE_CYCLES(20), .SLOT_CYCLES(10), .MAKER_CODE(MAKER),
    .SILICON_REV(REV)) u_monitor_reset_config_control (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slave_addr(slave_addr),
    .rst_pin_in(rst_in), .rst_pin_out(rst_out), .rst_pin_oe(rst_oe), .chassis_intrusion_pin_in(chs_in),
    .chassis_intrusion_pin_out(chs_out), .chassis_intrusion_pin_oe(chs_oe), .alert_n(alert_n),
    .cpu_voltage_code_pins(vcode), .cpu_voltage_code_msb_pin(vmsb), .addr_strap_lsb(a0),
    .addr_strap_msb(a1), .status1_set(set1), .status2_set(set2), .temp_lsb(tlsb),
    .conv_start(conv_start), .conv_chan(conv_chan), .monitor_busy(busy), .fan_drive_level(fan));

  host_pins_model u_host_pins_model (.clk(clk), .pull_req(pull_req), .intrude(intrude),
    .rst_oe(rst_oe), .chs_oe(chs_oe), .rst_level(rst_in), .chs_level(chs_in));

  ////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  task automatic end_of_test();
    $display("Checks: %0d, mismatches: %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic giveup();
    fail_count++;
    end_of_test();
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return rst_oe;
      1: return busy;
      default: return chs_oe;
    endcase
  endfunction

  task automatic wait_on(input int s, input logic v, output int n);
    for (n = 0; n < 300 && pick(s) !== v; n++) cyc(1);
    if (pick(s) !== v) giveup();
  endtask

  // Read results in order of issue
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0) chk8(reg_rdata, exp_q.pop_front());
    rd_seen = reg_rd;
  end

  initial begin
    #400000;
    giveup();
  end

  ////////////////////////////////////////
  // Main sequence
  initial begin
    int n;
    logic [7:0] d;
    logic [7:0] ad[15];
    logic [7:0] ex[15];
    d = rnd();
    vcode = d[3:0];
    vmsb = d[4];
    a0 = d[5];
    a1 = d[6];
    tlsb = d[7];
    cyc(6);
    rst = 1'b0;
    chk1(rst_oe, 1'b1);
    wait_on(0, 1'b0, n);
    chk1(n >= 20, 1'b1);
    ad = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h46, 8'h15, 8'h19, 8'h3e, 8'h3f, 8'h4b, 8'h47, 8'h48,
      8'h49, 8'h45};
    ex = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, MAKER, REV, {tlsb, 7'h01},
      {4'h5, vcode}, {6'h0b, a1, a0}, {7'h40, vmsb}, 8'h00};
    for (int i = 0; i < 15; i++) rd(ad[i], ex[i]);
    chk8({1'b0, slave_addr}, {3'h1, 3'h3, a1, a0});
    d = rnd();
    wr(8'h43, d);
    rd(8'h43, d);
    wr(8'h4b, d);
    rd(8'h4b, {tlsb, d[6:0]});
    wr(8'h3e, d);
    rd(8'h3e, MAKER);
    wr(8'h48, 8'hfc);
    rd(8'h48, {6'h3f, a1, a0});
    wr(8'h40, 8'h2a);
    rd(8'h40, 8'h0a);
    wr(8'h19, d);
    wr(8'h40, 8'h80);
    rd(8'h43, 8'h00);
    rd(8'h48, {6'h0b, a1, a0});
    rd(8'h19, d);
    chk8(fan, d);
    rd(8'h40, 8'h08);
    chk1(rst_oe, 1'b0);
    wr(8'h40, 8'h18);
    cyc(4);
    chk1(rst_oe, 1'b0);
    rd(8'h40, 8'h18);
    wr(8'h44, 8'h80);
    wait_on(0, 1'b1, n);
    rd(8'h40, 8'h08);
    rd(8'h44, 8'h80);
    wait_on(0, 1'b0, n);
    wr(8'h43, 8'h5a);
    wr(8'h19, 8'h77);
    cyc(8);
    pull_req = 1'b1;
    wait_on(0, 1'b1, n);
    pull_req = 1'b0;
    chk1(n <= 6, 1'b1);
    rd(8'h43, 8'h00);
    rd(8'h19, 8'h77);
    chk8(fan, 8'h77);
    wait_on(0, 1'b0, n);
    wr(8'h40, 8'h03);
    wait_on(1, 1'b1, n);
    chk1(n <= 2, 1'b1);
    cyc(25);
    wr(8'h40, 8'h02);
    chk1(busy, 1'b1);
    wait_on(1, 1'b0, n);
    wr(8'h40, 8'h03);
    wait_on(1, 1'b1, n);
    wr(8'h40, 8'h0b);
    wait_on(1, 1'b0, n);
    cyc(4);
    chk1(busy, 1'b0);
    wr(8'h40, 8'h00);
    set2 = 8'h01;
    cyc(1);
    set2 = 8'h00;
    cyc(2);
    chk1(alert_n, 1'b1);
    rd(8'h42, 8'h01);
    wr(8'h40, 8'h02);
    d = rnd() | 8'h01;
    set1 = d;
    cyc(1);
    set1 = 8'h00;
    cyc(2);
    chk1(alert_n, 1'b0);
    wr(8'h40, 8'h0a);
    chk1(alert_n, 1'b1);
    rd(8'h41, d);
    wr(8'h40, 8'h08);
    intrude = 1'b1;
    cyc(1);
    intrude = 1'b0;
    cyc(6);
    rd(8'h42, 8'h10);
    wr(8'h46, 8'h80);
    rd(8'h46, 8'h80);
    chk1(chs_oe, 1'b1);
    wait_on(2, 1'b0, n);
    cyc(10);
    rd(8'h42, 8'h10);
    rd(8'h42, 8'h00);
    wr(8'h40, 8'h40);
    chk1(chs_oe, 1'b1);
    wr(8'h40, 8'h00);
    wait_on(2, 1'b0, n);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk1(rst_oe, 1'b1);
    cyc(4);
    end_of_test();
  end
endmodule
